/* include/swt_pkg.sv */
package swt_pkg;
	// special-function bus address of the control register
	localparam logic [7:0] CTRL_ADDR    = 8'h8f;
	// reload register address (not in this stretch)
	localparam logic [7:0] RELOAD_ADDR  = 8'h86;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam int         FLAG_BIT     = 4;
	localparam int         RUN_BIT      = 3;
	localparam int         PS_HI        = 2;
	localparam int         PS_LO        = 0;
	localparam int         PS_W         = 11;
	localparam logic [7:0] CNT_RESET    = 8'h00;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} swt_sfr_req_t;

	typedef enum logic [1:0] {
		SWT_IDLE = 2'b00,
		SWT_RUN  = 2'b01
	} swt_state_t;
endpackage

/* verilog/swt_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module swt_prescaler (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [2:0] sel,
	output logic            tick
);
	logic [swt_pkg::PS_W-1:0] div_r;
	logic [swt_pkg::PS_W-1:0] mask;

	// terminal-count mask for ratios 1,4,16,64,256,512,1024,2048
	function automatic logic [swt_pkg::PS_W-1:0] ps_mask(input logic [2:0] s);
		case (s)
			3'h0:    ps_mask = 11'h000;
			3'h1:    ps_mask = 11'h003;
			3'h2:    ps_mask = 11'h00f;
			3'h3:    ps_mask = 11'h03f;
			3'h4:    ps_mask = 11'h0ff;
			3'h5:    ps_mask = 11'h1ff;
			3'h6:    ps_mask = 11'h3ff;
			default: ps_mask = 11'h7ff;
		endcase
	endfunction

	assign mask = ps_mask(sel);
	assign tick = run && ((div_r & mask) == mask);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_r <= 11'h000;
		end else if (!run) begin
			div_r <= 11'h000;
		end else begin
			div_r <= div_r + 11'h001;
		end
	end
endmodule
`default_nettype wire

/* verilog/swt_timer.sv */
// Summary of operation
// - counter overflow sets the overflow flag in control bit 4.
// - flag set with both enables active requests the service routine.
// - the counter never clears the flag; only reset or a software zero write does.
// - prescale code 0..7 divides by 1,4,16,64,256,512,1024,2048.
`timescale 1ns/1ps
`default_nettype none
module swt_timer (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire swt_pkg::swt_sfr_req_t sfr_req,
	output logic [7:0]                 sfr_rdata,
	input  wire logic                  wake_int_en,
	input  wire logic                  global_int_en,
	output logic                       wake_irq,
	output logic [7:0]                 wake_timer_count
);
	logic [7:0]          ctrl_r;
	logic [7:0]          reload_r;
	logic [7:0]          cnt_r;
	logic [7:0]          rdata_r;
	logic                tick;
	logic                ovf;
	logic                flag_wr;
	logic                run;
	swt_pkg::swt_state_t state_r;

	assign run = ctrl_r[swt_pkg::RUN_BIT];
	assign flag_wr = sfr_req.wr && (sfr_req.addr == swt_pkg::CTRL_ADDR);
	assign ovf = tick && (cnt_r == 8'hff);

	swt_prescaler u_ps (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.run     (run),
		.sel     (ctrl_r[swt_pkg::PS_HI:swt_pkg::PS_LO]),
		.tick    (tick)
	);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= swt_pkg::CTRL_RESET;
		end else begin
			if (flag_wr) begin
				ctrl_r <= {3'h0, sfr_req.wdata[4:0]};
			end
			// overflow wins over a simultaneous clear
			if (ovf) begin
				ctrl_r[swt_pkg::FLAG_BIT] <= 1'b1;
			end
		end
	end

	// writes while running are unpredictable; accepted as-is
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reload_r <= swt_pkg::RELOAD_RESET;
		end else if (sfr_req.wr && sfr_req.addr == swt_pkg::RELOAD_ADDR) begin
			reload_r <= sfr_req.wdata;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= swt_pkg::CNT_RESET;
		end else if (ovf) begin
			cnt_r <= reload_r;
		end else if (tick) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= swt_pkg::SWT_IDLE;
		end else begin
			case (state_r)
				swt_pkg::SWT_IDLE: state_r <= run ? swt_pkg::SWT_RUN : swt_pkg::SWT_IDLE;
				swt_pkg::SWT_RUN:  state_r <= run ? swt_pkg::SWT_RUN : swt_pkg::SWT_IDLE;
				default:           state_r <= swt_pkg::SWT_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
		end else if (sfr_req.rd) begin
			case (sfr_req.addr)
				swt_pkg::CTRL_ADDR:   rdata_r <= ctrl_r;
				swt_pkg::RELOAD_ADDR: rdata_r <= reload_r;
				default:              rdata_r <= 8'h00;
			endcase
		end
	end

	assign sfr_rdata = rdata_r;
	assign wake_timer_count = cnt_r;
	assign wake_irq = ctrl_r[swt_pkg::FLAG_BIT] && wake_int_en && global_int_en;
endmodule
`default_nettype wire

/* verification/swt_timer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module swt_timer_properties (
	input wire logic                  ref_clk,
	input wire logic                  sys_rst,
	input wire swt_pkg::swt_sfr_req_t sfr_req,
	input wire logic                  wake_int_en,
	input wire logic                  global_int_en,
	input wire logic                  wake_irq,
	input wire logic [7:0]            wake_timer_count
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic [3:0] ctl_r;
	wire  [7:0] q  = wake_timer_count;
	wire        en = wake_int_en && global_int_en;
	wire        cw = sfr_req.wr && sfr_req.addr == swt_pkg::CTRL_ADDR;
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst) ctl_r <= 4'h0;
		else if (cw) ctl_r <= sfr_req.wdata[3:0];
	a_irq_needs_en: assert property (wake_irq |-> en)
		else $error("irq unmasked");
	a_wrap_sets_flag: assert property ($past(q) == 8'hff && q != 8'hff && en |-> wake_irq)
		else $error("wrap no irq");
	a_flag_holds: assert property (wake_irq && !cw |=> wake_irq || !en)
		else $error("flag dropped");
	a_halt_freezes: assert property (!ctl_r[3] ##1 !ctl_r[3] |-> $stable(q))
		else $error("moved halted");
	a_code0_rate: assert property ((ctl_r == 4'h8) [*3] |-> $changed(q))
		else $error("slow tick");
	a_step_one: assert property ($changed(q) && $past(q) != 8'hff |-> q == $past(q) + 8'h01)
		else $error("bad step");
	c_irq: cover property (wake_irq);
	c_halt: cover property (ctl_r[3] ##1 !ctl_r[3]);
	c_slow: cover property (ctl_r == 4'hf);
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] CTL = swt_pkg::CTRL_ADDR;
	logic       ref_clk = 1'b0, sys_rst = 1'b1, gie = 1'b1, wie = 1'b1, irq;
	logic [7:0] rd, q;
	int         num_errors = 0, n_compared = 0;
	swt_pkg::swt_sfr_req_t req = '0;
	always #25 ref_clk = ~ref_clk;
	swt_timer i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_req(req), .sfr_rdata(rd),
		.wake_int_en(wie), .global_int_en(gie), .wake_irq(irq), .wake_timer_count(q));
	task automatic chk(input string s, input logic [11:0] v, input logic [11:0] e);
		n_compared++;
		if (v !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic tick(inout int n);
		@(posedge ref_clk) #1;
		n++;
		if (n > 2100) begin
			num_errors++;
			finish_test();
		end
	endtask
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk) req <= '{w, !w, a, d};
		@(posedge ref_clk) req <= '0;
		#1;
	endtask
	task automatic t_rates();
		logic [7:0] c;
		int n;
		for (int k = 7; k >= 0; k--) begin
			sfr(1'b1, CTL, 8'h08 | 8'(k));
			repeat (2) begin
				c = q;
				n = 0;
				while (q === c) tick(n);
			end
			chk("period", 12'(n), 12'(k < 4 ? 1 << 2 * k : 1 << k + 4));
		end
		sfr(1'b1, CTL, 8'h00);
		@(posedge ref_clk) #1 c = q;
		repeat (40) @(posedge ref_clk);
		chk("halt", 12'(q), 12'(c));
		$display("rates done");
	endtask
	task automatic t_flag();
		int n = 0;
		// clear any flag left by an overflow that met the halt write
		sfr(1'b1, CTL, 8'h00);
		sfr(1'b1, swt_pkg::RELOAD_ADDR, 8'hf0);
		sfr(1'b1, CTL, 8'h08);
		while (irq !== 1'b1) tick(n);
		chk("reload", 12'(q), 12'h0f0);
		sfr(1'b0, CTL, 8'h00);
		chk("flag", 12'(rd), 12'h018);
		@(posedge ref_clk) gie <= 1'b0;
		#1 chk("mask", 12'(irq), 12'h000);
		@(posedge ref_clk) begin
			gie <= 1'b1;
			wie <= 1'b0;
		end
		#1 chk("mask_wake", 12'(irq), 12'h000);
		@(posedge ref_clk) wie <= 1'b1;
		sfr(1'b1, CTL, 8'h10);
		repeat (20) @(posedge ref_clk);
		#1 chk("held", 12'(irq), 12'h001);
		sfr(1'b1, CTL, 8'h00);
		sfr(1'b0, CTL, 8'h00);
		chk("clear", 12'(rd), 12'h000);
		$display("flag done");
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		sfr(1'b0, CTL, 8'h00);
		chk("ctrl", 12'(rd), 12'(swt_pkg::CTRL_RESET));
		sfr(1'b0, 8'h80, 8'h00);
		chk("unmapped", 12'(rd), 12'h000);
		t_rates();
		t_flag();
		finish_test();
	end
endmodule
bind swt_timer swt_timer_properties i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.sfr_req(sfr_req), .wake_int_en(wake_int_en), .global_int_en(global_int_en),
	.wake_irq(wake_irq), .wake_timer_count(wake_timer_count));
`default_nettype wire
